// ---- readout_pkg.sv ----
// constants, field layout and scan states of the sensor readout logic
// assumes a single 25 MHz system clock and a separate serial clock
package readout_pkg;

  localparam int unsigned CFG_W       = 32;
  localparam int unsigned FIELD_W     = 10;
  localparam int unsigned ADDR_W      = 11;
  localparam int unsigned DAC_W       = 7;
  localparam int unsigned LEVEL_W     = 10;

  localparam int unsigned ROW_DIR_BIT = 0;
  localparam int unsigned ROW_ST_LSB  = 1;
  localparam int unsigned AVG_EN_BIT  = 11;
  localparam int unsigned SUBS_BIT    = 12;
  localparam int unsigned COL_DIR_BIT = 13;
  localparam int unsigned COL_ST_LSB  = 14;
  localparam int unsigned OUT_CNT_BIT = 24;
  localparam int unsigned DAC_LSB     = 25;

  localparam logic [CFG_W-1:0]  CFG_RESET  = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_LAST  = 11'h7FF;
  localparam logic [ADDR_W-1:0] ADDR_ZERO  = 11'h000;
  localparam logic [ADDR_W:0]   STEP_BASE  = 12'h002;
  localparam logic [ADDR_W-1:0] PAIR_OFS   = 11'h001;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 10'h000;

  localparam int unsigned FIFO_DEPTH  = 8;
  // pixel word: dual flag, row address, column address
  localparam int unsigned PIX_W       = 1 + 2 * ADDR_W;

  // index of each synchronised pin inside the sampler vector
  localparam int unsigned PIN_SYNC_X  = 0;
  localparam int unsigned PIN_CLK_X   = 1;
  localparam int unsigned PIN_SYNC_Y  = 2;
  localparam int unsigned PIN_CLK_Y   = 3;
  localparam int unsigned PIN_SH_N    = 4;
  localparam int unsigned PIN_PRE_A   = 5;
  localparam int unsigned PIN_PRE_B   = 6;
  localparam int unsigned PIN_AVG     = 7;
  localparam int unsigned PIN_LOAD    = 8;
  localparam int unsigned PIN_N       = 9;
  localparam logic [PIN_N-1:0] PIN_RESET = 9'h000;

  typedef enum logic [2:0] {
    COL_IDLE = 3'b001,
    COL_SCAN = 3'b010,
    COL_DONE = 3'b100
  } col_state_t;

endpackage : readout_pkg

// ---- pixel_fifo.sv ----
// small synchronous fifo carrying selected pixel words
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int unsigned WIDTH = 23,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0]      wr_q;
  logic [PW:0]      wr_d;
  logic [PW:0]      rd_q;
  logic [PW:0]      rd_d;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready  = !((wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]));
    out_valid = (wr_q != rd_q);
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_d      = push ? wr_q + 1'b1 : wr_q;
    rd_d      = pop ? rd_q + 1'b1 : rd_q;
    out_data  = mem_q[rd_q[PW-1:0]];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage carries no reset; words are read only once written
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[PW-1:0]] <= in_data;
    end
  end

endmodule : pixel_fifo

// ---- sensor_row_readout_and_config.sv ----
// sensor readout digital core: serial configuration, row and column
// addressing, column track and hold, pixel address stream
// assumes controller pins are asynchronous to clk; spi_clk is its own domain
`timescale 1ns/1ps
module sensor_row_readout_and_config
  import readout_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          spi_clk,
  input  wire logic                          spi_data,
  input  wire logic                          spi_load,
  output logic                               spi_check,
  input  wire logic                          row_sync,
  input  wire logic                          row_clock,
  input  wire logic                          col_sync,
  input  wire logic                          pixel_clock,
  input  wire logic                          column_sample_hold_n,
  input  wire logic                          output_bus_precharge_a,
  input  wire logic                          output_bus_precharge_b,
  input  wire logic                          averaging_pulse,
  input  wire logic [readout_pkg::LEVEL_W-1:0] column_level,
  output logic      [readout_pkg::LEVEL_W-1:0] held_level,
  output logic                               bus_precharged,
  output logic                               averaging_active,
  output logic      [readout_pkg::ADDR_W-1:0]  row_addr,
  output logic      [readout_pkg::ADDR_W-1:0]  col_addr,
  output logic                               end_of_line,
  output logic                               dual_output,
  output logic      [readout_pkg::DAC_W-1:0]   dac_level,
  output logic                               pix_valid,
  input  wire logic                          pix_ready,
  output logic      [readout_pkg::PIX_W-1:0]   pix_data
);

  import readout_pkg::*;

  function automatic logic [ADDR_W-1:0] start_addr(
    input logic [FIELD_W-1:0] field
  );
    start_addr = {field, 1'b0};
  endfunction : start_addr

  ////////////////////////////////////////////////////////////////////////////
  // serial shift chain, spi_clk domain

  logic [CFG_W-1:0] shift_q;
  logic [CFG_W-1:0] shift_d;
  logic             check_q;
  logic             check_d;

  always_comb begin
    shift_d = {spi_data, shift_q[CFG_W-1:1]};
    check_d = shift_q[0];
  end

  always_ff @(posedge spi_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= CFG_RESET;
      check_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      check_q <= check_d;
    end
  end

  assign spi_check = check_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin samplers, two flops each, third stage for edges

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] meta_q;
  logic [PIN_N-1:0] pin_q;
  logic [PIN_N-1:0] prev_q;
  logic [PIN_N-1:0] rise;
  logic [PIN_N-1:0] fall;

  always_comb begin
    pin_raw             = PIN_RESET;
    pin_raw[PIN_SYNC_X] = col_sync;
    pin_raw[PIN_CLK_X]  = pixel_clock;
    pin_raw[PIN_SYNC_Y] = row_sync;
    pin_raw[PIN_CLK_Y]  = row_clock;
    pin_raw[PIN_SH_N]   = column_sample_hold_n;
    pin_raw[PIN_PRE_A]  = output_bus_precharge_a;
    pin_raw[PIN_PRE_B]  = output_bus_precharge_b;
    pin_raw[PIN_AVG]    = averaging_pulse;
    pin_raw[PIN_LOAD]   = spi_load;
    rise                = pin_q & ~prev_q;
    fall                = ~pin_q & prev_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= PIN_RESET;
      pin_q  <= PIN_RESET;
      prev_q <= PIN_RESET;
    end else begin
      meta_q <= pin_raw;
      pin_q  <= meta_q;
      prev_q <= pin_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration word; shift chain is stable while load is high

  logic [CFG_W-1:0] cfg_q;
  logic [CFG_W-1:0] cfg_d;

  always_comb begin
    cfg_d = cfg_q;
    if (rise[PIN_LOAD]) begin
      cfg_d = shift_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // field decode
  logic               row_up;
  logic [ADDR_W-1:0]  row_start;
  logic               avg_en;
  logic               subsample;
  logic               col_rtl;
  logic [ADDR_W-1:0]  col_start;
  logic               two_outputs;
  logic [ADDR_W:0]    col_step;

  always_comb begin
    row_up      = cfg_q[ROW_DIR_BIT];
    row_start   = start_addr(cfg_q[ROW_ST_LSB +: FIELD_W]);
    avg_en      = cfg_q[AVG_EN_BIT];
    subsample   = cfg_q[SUBS_BIT];
    col_rtl     = cfg_q[COL_DIR_BIT];
    col_start   = start_addr(cfg_q[COL_ST_LSB +: FIELD_W]);
    two_outputs = cfg_q[OUT_CNT_BIT];
    col_step    = subsample ? (STEP_BASE << 1) : STEP_BASE;
  end

  assign dual_output = two_outputs;
  assign dac_level   = cfg_q[DAC_LSB +: DAC_W];

  ////////////////////////////////////////////////////////////////////////////
  // row addressing

  logic [ADDR_W-1:0] row_q;
  logic [ADDR_W-1:0] row_d;

  always_comb begin
    row_d = row_q;
    if (pin_q[PIN_SYNC_Y]) begin
      row_d = row_start;
    end else if (rise[PIN_CLK_Y]) begin
      row_d = row_up ? row_q - PAIR_OFS : row_q + PAIR_OFS;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      row_q <= ADDR_ZERO;
    end else begin
      row_q <= row_d;
    end
  end

  assign row_addr = row_q;

  ////////////////////////////////////////////////////////////////////////////
  // column scan and pixel word generation

  col_state_t        st_q;
  col_state_t        st_d;
  logic [ADDR_W-1:0] col_q;
  logic [ADDR_W-1:0] col_d;
  logic              eol_q;
  logic              eol_d;
  logic              push;
  logic [PIX_W-1:0]  word;
  logic              fifo_ready;
  logic [ADDR_W-1:0] second_col;
  logic              at_end;
  logic              advance;

  always_comb begin
    st_d       = st_q;
    col_d      = col_q;
    eol_d      = eol_q;
    push       = 1'b0;
    advance    = 1'b0;
    second_col = col_rtl ? col_q - PAIR_OFS : col_q + PAIR_OFS;
    word       = {two_outputs, row_q, col_q};
    at_end     = col_rtl ? ({1'b0, col_q} < col_step)
                         : ({1'b0, col_q} + col_step > {1'b0, ADDR_LAST});
    unique case (st_q)
      COL_IDLE, COL_DONE: begin
        if (pin_q[PIN_SYNC_X] && rise[PIN_CLK_X]) begin
          col_d = col_start;
          eol_d = 1'b0;
          st_d  = COL_SCAN;
        end
      end
      COL_SCAN: begin
        if (pin_q[PIN_SYNC_X]) begin
          col_d = col_start;
        end else if (rise[PIN_CLK_X]) begin
          push    = 1'b1;
          advance = two_outputs;
        end else if (fall[PIN_CLK_X] && !two_outputs) begin
          push    = 1'b1;
          word    = {1'b0, row_q, second_col};
          advance = 1'b1;
        end
        // a full buffer holds the scan on the current pixel
        if (advance && fifo_ready) begin
          if (at_end) begin
            eol_d = 1'b1;
            st_d  = COL_DONE;
          end else if (col_rtl) begin
            col_d = col_q - col_step[ADDR_W-1:0];
          end else begin
            col_d = col_q + col_step[ADDR_W-1:0];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= COL_IDLE;
      col_q <= ADDR_ZERO;
      eol_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      col_q <= col_d;
      eol_q <= eol_d;
    end
  end

  assign col_addr    = col_q;
  assign end_of_line = eol_q;

  pixel_fifo #(
    .WIDTH (PIX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (word),
    .out_valid (pix_valid),
    .out_ready (pix_ready),
    .out_data  (pix_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // column track and hold, bus precharge, averaging

  logic [LEVEL_W-1:0] level_q;
  logic [LEVEL_W-1:0] level_d;
  logic               pre_q;
  logic               pre_d;
  logic               avg_q;
  logic               avg_d;

  always_comb begin
    level_d = level_q;
    if (!pin_q[PIN_SH_N]) begin
      level_d = column_level;
    end
    pre_d = pin_q[PIN_PRE_A] && pin_q[PIN_PRE_B];
    // averaging acts only on a held level
    avg_d = avg_en && pin_q[PIN_AVG] && pin_q[PIN_SH_N];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= LEVEL_RST;
      pre_q   <= 1'b0;
      avg_q   <= 1'b0;
    end else begin
      level_q <= level_d;
      pre_q   <= pre_d;
      avg_q   <= avg_d;
    end
  end

  assign held_level       = level_q;
  assign bus_precharged   = pre_q;
  assign averaging_active = avg_q;

endmodule : sensor_row_readout_and_config

// ---- readout_asserts.sv ----
// checker for the readout core, bound to its top module
// assumes rst_n clears both the clk and the spi_clk domain
`timescale 1ns/1ps
module readout_asserts
  import readout_pkg::*;
(
  input wire logic                            clk,
  input wire logic                            rst_n,
  input wire logic                            spi_clk,
  input wire logic                            spi_data,
  input wire logic                            spi_load,
  input wire logic                            spi_check,
  input wire logic                            row_sync,
  input wire logic                            row_clock,
  input wire logic                            col_sync,
  input wire logic                            column_sample_hold_n,
  input wire logic                            output_bus_precharge_a,
  input wire logic                            output_bus_precharge_b,
  input wire logic                            averaging_pulse,
  input wire logic [readout_pkg::LEVEL_W-1:0] column_level,
  input wire logic [readout_pkg::LEVEL_W-1:0] held_level,
  input wire logic                            bus_precharged,
  input wire logic                            averaging_active,
  input wire logic [readout_pkg::ADDR_W-1:0]  row_addr,
  input wire logic [readout_pkg::ADDR_W-1:0]  col_addr,
  input wire logic                            end_of_line,
  input wire logic                            dual_output,
  input wire logic [readout_pkg::DAC_W-1:0]   dac_level,
  input wire logic                            pix_valid,
  input wire logic                            pix_ready,
  input wire logic [readout_pkg::PIX_W-1:0]   pix_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////
  // serial edges since reset, saturating once the chain is full
  logic [5:0] edges_q;
  logic [5:0] edges_d;
  always_comb edges_d = (edges_q == 6'h21) ? edges_q : edges_q + 6'h01;
  always_ff @(posedge spi_clk or negedge rst_n) begin
    if (!rst_n) edges_q <= 6'h00;
    else        edges_q <= edges_d;
  end
  property p_chain;
    @(posedge spi_clk) disable iff (!rst_n)
    edges_q == 6'h21 |-> spi_check == $past(spi_data, 33);
  endproperty
  a_chain: assert property (p_chain)
    else $error("serial check bit differs from shifted data");
  property p_load;
    $changed(dual_output) || $changed(dac_level) |-> $past(spi_load, 2);
  endproperty
  a_load: assert property (p_load)
    else $error("configuration changed without load");
  property p_hold;
    column_sample_hold_n [*6] |-> $stable(held_level);
  endproperty
  a_hold: assert property (p_hold)
    else $error("held level moved while holding");
  property p_track;
    (!column_sample_hold_n) [*6] |=> held_level == $past(column_level);
  endproperty
  a_track: assert property (p_track)
    else $error("held level not tracking");
  property p_pre;
    (output_bus_precharge_a && output_bus_precharge_b) [*5] |->
      bus_precharged;
  endproperty
  a_pre: assert property (p_pre)
    else $error("bus precharge not flagged");
  property p_avg;
    (!averaging_pulse) [*5] |-> !averaging_active;
  endproperty
  a_avg: assert property (p_avg)
    else $error("averaging flagged without pulse");
  property p_row_even;
    row_sync [*6] |-> !row_addr[0];
  endproperty
  a_row_even: assert property (p_row_even)
    else $error("row start not twice the field");
  property p_row_quiet;
    (!row_sync && !row_clock) [*6] |-> $stable(row_addr);
  endproperty
  a_row_quiet: assert property (p_row_quiet)
    else $error("row moved without row clock");
  property p_col_even;
    col_sync [*6] |-> !col_addr[0];
  endproperty
  a_col_even: assert property (p_col_even)
    else $error("column start not twice the field");
  property p_eol;
    $rose(end_of_line) |-> col_addr >= 11'h7FC || col_addr <= 11'h003;
  endproperty
  a_eol: assert property (p_eol)
    else $error("line end away from the array edge");
  property p_pix;
    pix_valid && !pix_ready |=> pix_valid && $stable(pix_data);
  endproperty
  a_pix: assert property (p_pix)
    else $error("pixel word dropped before taken");
  c_eol: cover property ($rose(end_of_line));
  c_pop: cover property (pix_valid && pix_ready);
  c_cfg: cover property ($changed(dac_level));
endmodule : readout_asserts

// ---- controller_model.sv ----
// behavioural camera controller driving the readout pins
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
module controller_model (
  output logic spi_clk,
  output logic spi_data,
  output logic spi_load,
  output logic row_sync,
  output logic row_clock,
  output logic col_sync,
  output logic pixel_clock,
  output logic column_sample_hold_n,
  output logic output_bus_precharge_a,
  output logic output_bus_precharge_b,
  output logic averaging_pulse
);
  initial begin
    {spi_clk, spi_data, spi_load, row_sync, row_clock} = 5'h00;
    {col_sync, pixel_clock, averaging_pulse} = 3'h0;
    column_sample_hold_n = 1'b0;
    {output_bus_precharge_a, output_bus_precharge_b} = 2'h0;
  end
  task automatic spi_ticks(input int n);
    repeat (n) begin
      #24 spi_clk = 1'b1;
      #24 spi_clk = 1'b0;
    end
  endtask : spi_ticks
  // lsb first; the idle line shows the inverse of the last bit
  task automatic shift_word(input logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      spi_data = w[i];
      spi_ticks(1);
    end
    spi_data = ~w[31];
  endtask : shift_word
  task automatic load_word;
    #48 spi_load = 1'b1;
    #200 spi_load = 1'b0;
  endtask : load_word
  task automatic row_start;
    row_sync = 1'b1;
    #80 row_clock = 1'b1;
    #80 row_clock = 1'b0;
    #160 row_sync = 1'b0;
  endtask : row_start
  // backup timing; precharge stretched so the sampled flag sees it
  task automatic next_row;
    row_clock = 1'b1;
    output_bus_precharge_a = 1'b1;
    output_bus_precharge_b = 1'b1;
    #160 column_sample_hold_n = 1'b1;
    #80 {output_bus_precharge_a, output_bus_precharge_b} = 2'h0;
    row_clock = 1'b0;
    averaging_pulse = 1'b1;
    #200 averaging_pulse = 1'b0;
    #200 column_sample_hold_n = 1'b0;
  endtask : next_row
  task automatic line(input int n);
    col_sync = 1'b1;
    #100 pixel_clock = 1'b1;
    #200 pixel_clock = 1'b0;
    #100 col_sync = 1'b0;
    repeat (n) begin
      #200 pixel_clock = 1'b1;
      #200 pixel_clock = 1'b0;
    end
  endtask : line
endmodule : controller_model

// ---- sensor_row_readout_and_config_tb.sv ----
// bench for the readout core: controller model plus pixel sink
// assumes 25 MHz clk; spi_clk runs only during reset and while a word is shifted
`timescale 1ns/1ps
module sensor_row_readout_and_config_tb import readout_pkg::*;;
  logic                 clk;
  logic                 rst_n;
  logic                 pix_ready;
  logic [LEVEL_W-1:0]   column_level;
  logic                 spi_clk, spi_data, spi_load, row_sync, row_clock;
  logic                 col_sync, pixel_clock, column_sample_hold_n;
  logic                 output_bus_precharge_a, output_bus_precharge_b;
  logic                 averaging_pulse, spi_check, bus_precharged;
  logic                 averaging_active, end_of_line, dual_output;
  logic                 pix_valid;
  logic [LEVEL_W-1:0]   held_level;
  logic [ADDR_W-1:0]    row_addr, col_addr, row_exp;
  logic [DAC_W-1:0]     dac_level;
  logic [PIX_W-1:0]     pix_data;
  logic [PIX_W-1:0]     exp_q[$];
  logic [31:0]          rng, tmp, cfg;
  int                   n_errors, checks_done;
  sensor_row_readout_and_config i_dut (
    .clk, .rst_n, .spi_clk, .spi_data, .spi_load, .spi_check, .row_sync,
    .row_clock, .col_sync, .pixel_clock, .column_sample_hold_n,
    .output_bus_precharge_a, .output_bus_precharge_b, .averaging_pulse,
    .column_level, .held_level, .bus_precharged, .averaging_active,
    .row_addr, .col_addr, .end_of_line, .dual_output, .dac_level,
    .pix_valid, .pix_ready, .pix_data);
  controller_model i_ctl (
    .spi_clk, .spi_data, .spi_load, .row_sync, .row_clock, .col_sync,
    .pixel_clock, .column_sample_hold_n, .output_bus_precharge_a,
    .output_bus_precharge_b, .averaging_pulse);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    #1;
    rng = xs(rng);
    column_level = rng[9:0];
    pix_ready = rng[12] | rng[13];
  end
  // sink side: oldest expected word against each accepted word
  always @(posedge clk) begin
    if (rst_n === 1'b1 && pix_valid === 1'b1 && pix_ready === 1'b1) begin
      if (exp_q.size() == 0)
        cmp(32'h1, 32'h0);
      else
        cmp(32'(pix_data), 32'(exp_q.pop_front()));
    end
  end
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    {rst_n, n_errors, checks_done} = '0;
    rng = 32'h4E4B;
    tmp = xs(32'h4E4B);
    // row up from an even start, one output pair, column near the end
    cfg = {tmp[22:16], 1'b1, 10'h3FD, 3'h1, 1'b0, tmp[8:0] + 9'h001, 1'b1};
    row_exp = {cfg[10:1], 1'b0} - 11'h001;
    fork
      i_ctl.spi_ticks(2);
      repeat (10) @(posedge clk);
    join
    #1 rst_n = 1'b1;
    @(posedge clk);
    #1;
    cmp({row_addr, col_addr, dual_output, dac_level, end_of_line,
         pix_valid}, 32'h0);
    i_ctl.shift_word(tmp);
    i_ctl.shift_word(cfg);
    repeat (4) @(posedge clk);
    #1 cmp(32'({dac_level, dual_output}), 32'h0);
    i_ctl.load_word();
    repeat (4) @(posedge clk);
    #1 cmp(32'({dac_level, dual_output}), 32'(cfg[31:24]));
    i_ctl.row_start();
    repeat (5) @(posedge clk);
    #1 cmp(32'(row_addr), 32'({cfg[10:1], 1'b0}));
    fork
      i_ctl.next_row();
      begin
        #160 cmp(32'(bus_precharged), 32'h1);
        #240 cmp(32'(averaging_active), 32'h1);
      end
    join
    cmp(32'(row_addr), 32'(row_exp));
    for (int i = 0; i < 3; i++)
      exp_q.push_back({1'b1, row_exp, 11'h7FA + 11'(2 * i)});
    i_ctl.line(3);
    repeat (40) @(posedge clk);
    #1 cmp(32'(end_of_line), 32'h1);
    cmp(32'(exp_q.size()), 32'h0);
    // one output, subsampled, right to left, line cut after two periods
    cfg = {tmp[6:0], 1'b0, 10'h200, 3'h6, cfg[10:1], 1'b0};
    i_ctl.shift_word(cfg);
    i_ctl.load_word();
    repeat (4) @(posedge clk);
    #1 cmp(32'({dac_level, dual_output}), 32'(cfg[31:24]));
    for (int i = 0; i < 4; i++)
      exp_q.push_back({1'b0, row_exp, 11'h400 - 11'(4 * (i / 2) + i % 2)});
    i_ctl.line(2);
    repeat (40) @(posedge clk);
    #1 cmp(32'({end_of_line, col_addr}), 32'h3F8);
    cmp(32'(exp_q.size()), 32'h0);
    tally_and_finish();
  end
endmodule : sensor_row_readout_and_config_tb
bind sensor_row_readout_and_config readout_asserts i_chk (
  .clk, .rst_n, .spi_clk, .spi_data, .spi_load, .spi_check, .row_sync,
  .row_clock, .col_sync, .column_sample_hold_n, .output_bus_precharge_a,
  .output_bus_precharge_b, .averaging_pulse, .column_level, .held_level,
  .bus_precharged, .averaging_active, .row_addr, .col_addr, .end_of_line,
  .dual_output, .dac_level, .pix_valid, .pix_ready, .pix_data);
